// *** src/kpi_pkg.sv ***
/*
 * kpi_pkg: register map, field positions, bus codes and shared types
 * for the keypad pin interrupt unit.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package kpi_pkg;

    // register byte offsets, one aligned word each
    localparam logic [7:0] KPI_OFS_STATUS_CTRL = 8'h00;
    localparam logic [7:0] KPI_OFS_PIN_ENABLE  = 8'h04;
    localparam logic [7:0] KPI_OFS_PIN_POLAR   = 8'h08;

    // decoded register selector
    localparam logic [1:0] KPI_SEL_STATUS_CTRL = 2'h0;
    localparam logic [1:0] KPI_SEL_PIN_ENABLE  = 2'h1;
    localparam logic [1:0] KPI_SEL_PIN_POLAR   = 2'h2;
    localparam logic [1:0] KPI_SEL_NONE        = 2'h3;

    // key_status_control field positions
    localparam int KPI_BIT_PENDING = 3;
    localparam int KPI_BIT_ACK     = 2;
    localparam int KPI_BIT_MASK    = 1;
    localparam int KPI_BIT_MODE    = 0;

    // register width and reset values
    localparam int         KPI_REG_W        = 8;
    localparam logic [7:0] KPI_RST_ENABLE   = 8'h00;
    localparam logic [7:0] KPI_RST_POLARITY = 8'h00;
    localparam logic       KPI_RST_MASK     = 1'b0;
    localparam logic       KPI_RST_MODE     = 1'b0;

    // AXI response codes
    localparam logic [1:0] KPI_RESP_OKAY   = 2'h0;
    localparam logic [1:0] KPI_RESP_SLVERR = 2'h2;

    // control bits of key_status_control that software keeps
    typedef struct packed {
        logic mask;
        logic mode;
    } kpi_ctrl_type;

    // bus channel states
    typedef enum logic [1:0] {
        KPI_CH_IDLE = 2'b00,
        KPI_CH_RESP = 2'b01
    } kpi_ch_state_type;

endpackage

// *** src/kpi_keypad_irq.sv ***
/*
 * kpi_keypad_irq: keypad pin interrupt unit with an AXI4-Lite slave.
 * Watches key pins, latches one shared request and drives a maskable
 * interrupt. Assumes aclk at 40 MHz, synchronous active-low reset, a
 * one-cycle vector fetch pulse from the core, and an outside pad and
 * break controller that use the pull and break signals.
 */
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module kpi_keypad_irq #(
    parameter int NUM_PINS = 6
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [31:0]         s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [31:0]         s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic [NUM_PINS-1:0] key_input_pins,
    input  wire logic                vector_fetch_ack,
    input  wire logic                break_active,
    input  wire logic                break_clear_enable,
    output logic                     irq_req,
    output logic                     wake_req,
    output logic [NUM_PINS-1:0]      pull_up_en,
    output logic [NUM_PINS-1:0]      pull_down_en,
    output logic [NUM_PINS-1:0]      pin_force_input
);

    // byte address to register selector, shared by both channels
    function automatic logic [1:0] reg_sel(input logic [31:0] addr);
        logic [1:0] sel;
        sel = kpi_pkg::KPI_SEL_NONE;
        if (addr[31:8] == 24'h000000) begin
            case (addr[7:0])
                kpi_pkg::KPI_OFS_STATUS_CTRL:
                    sel = kpi_pkg::KPI_SEL_STATUS_CTRL;
                kpi_pkg::KPI_OFS_PIN_ENABLE:
                    sel = kpi_pkg::KPI_SEL_PIN_ENABLE;
                kpi_pkg::KPI_OFS_PIN_POLAR:
                    sel = kpi_pkg::KPI_SEL_PIN_POLAR;
                default:
                    sel = kpi_pkg::KPI_SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    kpi_pkg::kpi_ctrl_type          ctrl_q;
    logic [NUM_PINS-1:0]            en_q;
    logic [NUM_PINS-1:0]            pol_q;
    logic [NUM_PINS-1:0]            sync1_q;
    logic [NUM_PINS-1:0]            sync2_q;
    logic [NUM_PINS-1:0]            prev_q;
    logic                           latch_q;
    logic                           vec_ack_q;
    logic [NUM_PINS-1:0]            asserted_now;
    logic [NUM_PINS-1:0]            asserted_prev;
    logic                           any_now;
    logic                           any_prev;
    logic                           edge_set;
    logic                           pending;
    logic                           sw_ack;
    logic                           ack_any;
    logic                           latch_d;

    kpi_pkg::kpi_ch_state_type      wr_state_q;
    kpi_pkg::kpi_ch_state_type      rd_state_q;
    logic                           aw_full_q;
    logic                           w_full_q;
    logic [31:0]                    aw_addr_q;
    logic [31:0]                    w_data_q;
    logic                           w_lane0_q;
    logic                           aw_take;
    logic                           w_take;
    logic                           aw_have;
    logic                           w_have;
    logic                           wr_fire;
    logic [31:0]                    wr_addr;
    logic [31:0]                    wr_data;
    logic                           wr_lane0;
    logic [1:0]                     wr_sel;
    logic                           wr_ok;
    logic                           ar_take;
    logic [1:0]                     rd_sel;
    logic [31:0]                    rd_word;
    logic                           sts_protect;

    // two-flop pin synchroniser plus one older sample for edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else begin
            sync1_q <= key_input_pins;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // per-pin assertion, from the current and the one-older sample
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            assign asserted_now[gi]  = en_q[gi] &
                                       (pol_q[gi] ? sync2_q[gi]
                                                  : ~sync2_q[gi]);
            assign asserted_prev[gi] = en_q[gi] &
                                       (pol_q[gi] ? prev_q[gi]
                                                  : ~prev_q[gi]);
        end
    endgenerate

    // combined view: an edge only counts when no other pin was asserted
    assign any_now  = |asserted_now;
    assign any_prev = |asserted_prev;
    assign edge_set = any_now & ~any_prev;

    // break protects status unless the clear enable is set
    // break blocks the software status clear; a vector fetch still clears
    assign sts_protect = break_active & ~break_clear_enable;

    assign sw_ack  = wr_fire & wr_ok & wr_lane0 &
                     (wr_sel == kpi_pkg::KPI_SEL_STATUS_CTRL) &
                     wr_data[kpi_pkg::KPI_BIT_ACK] & ~sts_protect;
    assign ack_any = sw_ack | vec_ack_q;

    assign latch_d = edge_set | (latch_q & ~ack_any);

    assign pending = latch_q | (ctrl_q.mode & any_now);

    // request latch and vector pulse register
    // reset clears request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_q   <= 1'b0;
            vec_ack_q <= 1'b0;
        end else begin
            latch_q   <= latch_d;
            vec_ack_q <= vector_fetch_ack; // one-cycle pulse in
        end
    end

    // interrupt, wake and pad outputs, all registered
    // mask gates request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_req         <= 1'b0;
            wake_req        <= 1'b0;
            pull_up_en      <= '0;
            pull_down_en    <= '0;
            pin_force_input <= '0;
        end else begin
            irq_req         <= pending & ~ctrl_q.mask;
            wake_req        <= pending & ~ctrl_q.mask;
            pull_up_en      <= en_q & ~pol_q;
            pull_down_en    <= en_q & pol_q;
            pin_force_input <= en_q;
        end
    end

    // write channel: address and data taken in either order
    assign aw_take  = s_axi_awvalid & s_axi_awready;
    assign w_take   = s_axi_wvalid & s_axi_wready;
    assign aw_have  = aw_full_q | aw_take;
    assign w_have   = w_full_q | w_take;
    assign wr_fire  = (wr_state_q == kpi_pkg::KPI_CH_IDLE) &
                      aw_have & w_have;
    assign wr_addr  = aw_full_q ? aw_addr_q : s_axi_awaddr;
    assign wr_data  = w_full_q ? w_data_q : s_axi_wdata;
    assign wr_lane0 = w_full_q ? w_lane0_q : s_axi_wstrb[0];
    assign wr_sel   = reg_sel(wr_addr);
    assign wr_ok    = (wr_sel != kpi_pkg::KPI_SEL_NONE);

    // write channel handshake and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q    <= kpi_pkg::KPI_CH_IDLE;
            aw_full_q     <= 1'b0;
            w_full_q      <= 1'b0;
            aw_addr_q     <= '0;
            w_data_q      <= '0;
            w_lane0_q     <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= kpi_pkg::KPI_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_q  <= s_axi_wdata;
                w_lane0_q <= s_axi_wstrb[0];
            end
            case (wr_state_q)
                kpi_pkg::KPI_CH_IDLE: begin
                    if (wr_fire) begin
                        wr_state_q    <= kpi_pkg::KPI_CH_RESP;
                        aw_full_q     <= 1'b0;
                        w_full_q      <= 1'b0;
                        s_axi_awready <= 1'b0;
                        s_axi_wready  <= 1'b0;
                        s_axi_bvalid  <= 1'b1;
                        s_axi_bresp   <= wr_ok ? kpi_pkg::KPI_RESP_OKAY
                                               : kpi_pkg::KPI_RESP_SLVERR;
                    end else begin
                        aw_full_q     <= aw_have;
                        w_full_q      <= w_have;
                        s_axi_awready <= ~aw_have;
                        s_axi_wready  <= ~w_have;
                    end
                end
                kpi_pkg::KPI_CH_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_q    <= kpi_pkg::KPI_CH_IDLE;
                        s_axi_bvalid  <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready  <= 1'b1;
                    end
                end
                default: begin
                    wr_state_q <= kpi_pkg::KPI_CH_IDLE;
                end
            endcase
        end
    end

    // software registers; only the low byte lane carries them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q.mask <= kpi_pkg::KPI_RST_MASK;
            ctrl_q.mode <= kpi_pkg::KPI_RST_MODE; // mode cleared
            en_q        <= kpi_pkg::KPI_RST_ENABLE[NUM_PINS-1:0];
            pol_q       <= kpi_pkg::KPI_RST_POLARITY[NUM_PINS-1:0];
        end else if (wr_fire & wr_lane0) begin
            case (wr_sel)
                kpi_pkg::KPI_SEL_STATUS_CTRL: begin
                    ctrl_q.mask <= wr_data[kpi_pkg::KPI_BIT_MASK];
                    ctrl_q.mode <= wr_data[kpi_pkg::KPI_BIT_MODE];
                end
                kpi_pkg::KPI_SEL_PIN_ENABLE: begin
                    en_q <= wr_data[NUM_PINS-1:0];
                end
                kpi_pkg::KPI_SEL_PIN_POLAR: begin
                    pol_q <= wr_data[NUM_PINS-1:0];
                end
                default: begin
                    en_q <= en_q;
                end
            endcase
        end
    end

    // read data mux; unused and reserved bits read zero
    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign rd_sel  = reg_sel(s_axi_araddr);
    always_comb begin
        rd_word = '0;
        case (rd_sel)
            kpi_pkg::KPI_SEL_STATUS_CTRL: begin
                rd_word[kpi_pkg::KPI_BIT_PENDING] = pending;
                rd_word[kpi_pkg::KPI_BIT_MASK]    = ctrl_q.mask;
                rd_word[kpi_pkg::KPI_BIT_MODE]    = ctrl_q.mode;
            end
            kpi_pkg::KPI_SEL_PIN_ENABLE: begin
                rd_word[NUM_PINS-1:0] = en_q;
            end
            kpi_pkg::KPI_SEL_PIN_POLAR: begin
                rd_word[NUM_PINS-1:0] = pol_q;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // read channel: one word per request, answer the edge after taking
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_q    <= kpi_pkg::KPI_CH_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= kpi_pkg::KPI_RESP_OKAY;
        end else begin
            case (rd_state_q)
                kpi_pkg::KPI_CH_IDLE: begin
                    s_axi_arready <= ~ar_take;
                    if (ar_take) begin
                        rd_state_q   <= kpi_pkg::KPI_CH_RESP;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rdata  <= rd_word;
                        s_axi_rresp  <= (rd_sel == kpi_pkg::KPI_SEL_NONE)
                                      ? kpi_pkg::KPI_RESP_SLVERR
                                      : kpi_pkg::KPI_RESP_OKAY;
                    end
                end
                kpi_pkg::KPI_CH_RESP: begin
                    if (s_axi_rready) begin
                        rd_state_q    <= kpi_pkg::KPI_CH_IDLE;
                        s_axi_rvalid  <= 1'b0;
                        s_axi_arready <= 1'b1;
                    end
                end
                default: begin
                    rd_state_q <= kpi_pkg::KPI_CH_IDLE;
                end
            endcase
        end
    end

    // checks on the request path and the pull outputs
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_sw_ack_quiet;
        sw_ack && !edge_set && !ctrl_q.mode;
    endsequence

    sequence s_level_held;
        (ctrl_q.mode && any_now && !ctrl_q.mask)[*2];
    endsequence

    property p_disabled_quiet;
        (en_q == '0) |-> !any_now;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("disabled pins asserted a request");

    property p_pull_select;
        ##1 1'b1 |-> (pull_up_en == ($past(en_q) & ~$past(pol_q))) &&
                     (pull_down_en == ($past(en_q) & $past(pol_q)));
    endproperty
    a_pull_select: assert property (p_pull_select)
        else $error("pull selection does not follow polarity");

    property p_edge_latches;
        edge_set |=> latch_q ##1 (latch_q || $past(ack_any));
    endproperty
    a_edge_latches: assert property (p_edge_latches)
        else $error("edge did not latch a request");

    property p_held_blocks_edge;
        (!ctrl_q.mode && any_prev && !latch_q) |=> !latch_q;
    endproperty
    a_held_blocks_edge: assert property (p_held_blocks_edge)
        else $error("edge latched while another pin was held");

    property p_level_holds;
        s_level_held |-> irq_req && wake_req;
    endproperty
    a_level_holds: assert property (p_level_holds)
        else $error("level request dropped while pin asserted");

    property p_sw_ack_clears;
        s_sw_ack_quiet |=> !latch_q;
    endproperty
    a_sw_ack_clears: assert property (p_sw_ack_clears)
        else $error("acknowledge did not clear the latch");

    property p_vec_ack_clears;
        (vector_fetch_ack && !ctrl_q.mode) ##1 !edge_set |=> !latch_q;
    endproperty
    a_vec_ack_clears: assert property (p_vec_ack_clears)
        else $error("vector fetch did not clear the latch");

    property p_mask_blocks;
        ctrl_q.mask |=> !irq_req && !wake_req;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("masked request reached the interrupt output");

    property p_unmasked_irq;
        (pending && !ctrl_q.mask) |=> irq_req;
    endproperty
    a_unmasked_irq: assert property (p_unmasked_irq)
        else $error("unmasked request not presented");

    property p_reset_clears;
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> !latch_q && !ctrl_q.mode && !irq_req;
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("reset left a request or mode set");

    property p_break_protects;
        (sts_protect && latch_q && !vec_ack_q) |=> latch_q;
    endproperty
    a_break_protects: assert property (p_break_protects)
        else $error("status cleared during protected break");

endmodule

`default_nettype wire

// *** dv/kpi_key_model.sv ***
/*
 * kpi_key_model: six key switches on the keypad pins.
 * Assumes the unit's pull enables tell which rail a closed switch meets.
 */
`timescale 1ns/1ps
`default_nettype none
module kpi_key_model (
    input  wire logic       aclk,
    input  wire logic [5:0] press,
    input  wire logic [5:0] pull_up_en,
    input  wire logic [5:0] pull_down_en,
    output logic      [5:0] key_input_pins
);
    logic float_q = 1'h0;

    // an open, unpulled pin wanders; toggle so no stale level is trusted
    always @(posedge aclk) begin
        float_q <= ~float_q;
    end

    // closed switch shorts to the rail opposite its pull
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (press[i])
                key_input_pins[i] = pull_down_en[i];
            else if (pull_up_en[i] | pull_down_en[i])
                key_input_pins[i] = pull_up_en[i];
            else
                key_input_pins[i] = float_q;
        end
    end
endmodule
`default_nettype wire

// *** dv/test_keypad_pin_interrupt.sv ***
/*
 * test_keypad_pin_interrupt: register-level bench for kpi_keypad_irq.
 * Assumes the switch model beside it and a 40 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module test_keypad_pin_interrupt;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0, vfa = 1'h0;
    logic        brk = 1'h0, bce = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, irq, wake;
    logic [1:0]  bresp, rresp;
    logic [5:0]  press = 6'h00, pins, pu, pd, fin;
    logic [3:0]  strb = 4'hF;
    int          errors = 0, tests_run = 0, cycles = 0;
    localparam logic [1:0] OK = kpi_pkg::KPI_RESP_OKAY;
    localparam logic [1:0] ERR = kpi_pkg::KPI_RESP_SLVERR;

    kpi_keypad_irq kpi_keypad_irq_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .key_input_pins(pins), .vector_fetch_ack(vfa), .break_active(brk),
        .break_clear_enable(bce), .irq_req(irq), .wake_req(wake),
        .pull_up_en(pu), .pull_down_en(pd), .pin_force_input(fin));
    kpi_key_model kpi_key_model_inst (.aclk(aclk), .press(press),
        .pull_up_en(pu), .pull_down_en(pd), .key_input_pins(pins));

    always #12.5 aclk = ~aclk;

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            errors++;
            final_report();
        end
    end

    task automatic final_report();
        if (errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // write: both channels offered together, each dropped once taken
    task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!bvalid);
        chk("bresp", {30'h0, bresp}, {30'h0, er});
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [31:0] a, e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
        end while (!rvalid);
        chk("rdata", rdata, e);
        chk("rresp", {30'h0, rresp}, {30'h0, er});
        rready <= 1'h0;
    endtask

    // new switch state, then the full sync-and-latch latency
    task automatic pr(input logic [5:0] p);
        @(posedge aclk);
        press <= p;
        repeat (6) @(posedge aclk);
    endtask

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        rd(32'h00, 32'h00, OK);
        rd(32'h04, 32'h00, OK);
        rd(32'h08, 32'h00, OK);
        rd(32'h0C, 32'h00, ERR);
        wr(32'h0C, 32'hFF, ERR);
        // masked setup, ack after the pulls settle
        wr(32'h00, 32'h02, OK);
        wr(32'h08, 32'h03, OK);
        wr(32'h04, 32'h3F, OK);
        repeat (8) @(posedge aclk);
        wr(32'h00, 32'h06, OK);
        wr(32'h00, 32'h00, OK);
        rd(32'h04, 32'h3F, OK);
        chk("pulls", {14'h0, pu, pd, fin},
            {14'h0, 6'h3C, 6'h03, 6'h3F});
        rd(32'h00, 32'h00, OK);
        pr(6'h04);
        rd(32'h00, 32'h08, OK);
        chk("irq", {30'h0, irq, wake}, 32'h03);
        wr(32'h00, 32'h02, OK);
        repeat (2) @(posedge aclk);
        chk("irq", {30'h0, irq, wake}, 32'h00);
        rd(32'h00, 32'h0A, OK);
        wr(32'h00, 32'h06, OK);
        rd(32'h00, 32'h02, OK);
        wr(32'h00, 32'h00, OK);
        pr(6'h0C);
        rd(32'h00, 32'h00, OK);
        pr(6'h00);
        pr(6'h01);
        rd(32'h00, 32'h08, OK);
        @(posedge aclk);
        vfa <= 1'h1;
        @(posedge aclk);
        vfa <= 1'h0;
        repeat (3) @(posedge aclk);
        rd(32'h00, 32'h00, OK);
        pr(6'h00);
        wr(32'h04, 32'h2F, OK);
        pr(6'h10);
        rd(32'h00, 32'h00, OK);
        // low byte lane off: the write must leave the enables alone
        strb <= 4'h0;
        wr(32'h04, 32'h00, OK);
        strb <= 4'hF;
        rd(32'h04, 32'h2F, OK);
        pr(6'h00);
        // level mode: ack while the pin is held, then release
        wr(32'h00, 32'h01, OK);
        pr(6'h20);
        rd(32'h00, 32'h09, OK);
        wr(32'h00, 32'h05, OK);
        rd(32'h00, 32'h09, OK);
        pr(6'h00);
        rd(32'h00, 32'h01, OK);
        wr(32'h00, 32'h00, OK);
        @(posedge aclk);
        brk <= 1'h1;
        pr(6'h02);
        wr(32'h00, 32'h04, OK);
        rd(32'h00, 32'h08, OK);
        bce <= 1'h1;
        wr(32'h00, 32'h04, OK);
        @(posedge aclk);
        brk <= 1'h0;
        bce <= 1'h0;
        rd(32'h00, 32'h00, OK);
        pr(6'h00);
        // reset with a level request held
        wr(32'h00, 32'h01, OK);
        pr(6'h01);
        rd(32'h00, 32'h09, OK);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        rd(32'h00, 32'h00, OK);
        chk("irq", {31'h0, irq}, 32'h00);
        final_report();
    end
endmodule
`default_nettype wire
